// ==== design/dma_external_request_grant.sv ====
`timescale 1ns/1ps
// What this block does
// - A burst for the external request starts only when its channel wins arbitration.
// - An external request that drops during a burst is lost; one held until it wins yields a full burst.
// - External grant output is active low; high means idle.
// - Grant only during a burst of an enabled, externally sourced, requesting channel.
// - Request input is not sampled from grant assertion to burst end.
// - After serving it, external request goes lowest when others pend.
// - Grant stays low at least eight clock cycles unless its channel is disabled mid-burst.
module dma_external_request_grant #(
    parameter int unsigned NCH = dma_xreq_pkg::NUM_CH,
    parameter int unsigned CW  = dma_xreq_pkg::CH_W
) (
    input  wire logic           ref_clk,
    input  wire logic           reset,
    input  wire logic           extReq,
    input  wire logic [NCH-1:0] chanReq,
    input  wire logic [NCH-1:0] requestEnable,
    input  wire logic [NCH-1:0] channel_enable_bit,
    input  wire logic [NCH-1:0] request_source_select,
    output logic                extGrant_n,
    output logic                burstActive,
    output logic [CW-1:0]       burstChan,
    output logic                readPhase,
    output logic                writePhase,
    output logic                burstDone
);

    typedef struct packed {
        dma_xreq_pkg::burst_st_t      st;
        logic [dma_xreq_pkg::CNT_W-1:0] cnt;
        logic [dma_xreq_pkg::CNT_W-1:0] grantCnt;
        logic [CW-1:0]                chan;
        logic                         grantOn;
        logic                         demote;
        logic                         done;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    logic [NCH-1:0] pending;
    logic [NCH-1:0] extSel;
    logic           anyPend;
    logic [CW-1:0]  winner;
    logic           extChanValid;
    logic [CW-1:0]  extChan;
    logic           burstExt;
    logic           burstEnd;

    // External request feeds only channels steered to it and enabled
    assign extSel = request_source_select & requestEnable & channel_enable_bit;

    // Lowest external channel is the one pushed back, after a burst of any external channel
    always_comb begin
        extChanValid = 1'b0;
        extChan      = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (extSel[i]) begin
                extChanValid = 1'b1;
                extChan      = CW'(i);
            end
        end
    end

    // Request is looked at only outside bursts, so changes in a burst are lost
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            pending[i] = requestEnable[i] && channel_enable_bit[i]
                         && (request_source_select[i] ? extReq : chanReq[i]);
        end
        if (cur_r.st != dma_xreq_pkg::ST_IDLE) begin
            pending = '0;
        end
    end

    dma_xreq_arb #(.NCH(NCH), .CW(CW)) u_arb (
        .pending   (pending),
        .extChan   (extChan),
        .extDemote (cur_r.demote && extChanValid),
        .anyPend   (anyPend),
        .winner    (winner)
    );

    assign burstExt = request_source_select[cur_r.chan] && requestEnable[cur_r.chan]
                      && channel_enable_bit[cur_r.chan];
    assign burstEnd = (cur_r.st == dma_xreq_pkg::ST_DONE)
                      && (cur_r.grantCnt >= dma_xreq_pkg::CNT_W'(dma_xreq_pkg::GRANT_MIN_CYC));

    always_comb begin
        cur_nxt      = cur_r;
        cur_nxt.done = 1'b0;
        if (cur_r.grantOn) begin
            cur_nxt.grantCnt = cur_r.grantCnt + 1'b1;
        end
        unique case (cur_r.st)
            dma_xreq_pkg::ST_IDLE: begin
                if (anyPend) begin
                    // Winner alone starts; an external channel waits its turn
                    cur_nxt.st       = dma_xreq_pkg::ST_READ;
                    cur_nxt.chan     = winner;
                    cur_nxt.cnt      = '0;
                    cur_nxt.grantCnt = '0;
                    // Request is registered here, so the grant may rely on it
                    cur_nxt.grantOn  = request_source_select[winner] && extReq;
                end
            end
            dma_xreq_pkg::ST_READ: begin
                cur_nxt.cnt = cur_r.cnt + 1'b1;
                if (cur_r.cnt == dma_xreq_pkg::CNT_W'(dma_xreq_pkg::READ_CYC - 1)) begin
                    cur_nxt.st  = dma_xreq_pkg::ST_WRITE;
                    cur_nxt.cnt = '0;
                end
            end
            dma_xreq_pkg::ST_WRITE: begin
                cur_nxt.cnt = cur_r.cnt + 1'b1;
                if (cur_r.cnt == dma_xreq_pkg::CNT_W'(dma_xreq_pkg::WRITE_CYC - 1)) begin
                    cur_nxt.st = dma_xreq_pkg::ST_DONE;
                end
            end
            dma_xreq_pkg::ST_DONE: begin
                // Short bursts stretch here so the grant meets its minimum
                if (burstEnd || !cur_r.grantOn) begin
                    cur_nxt.st      = dma_xreq_pkg::ST_IDLE;
                    cur_nxt.grantOn = 1'b0;
                    cur_nxt.done    = 1'b1;
                    // Sticks across idle time until the next burst ends
                    cur_nxt.demote  = burstExt;
                end
            end
        endcase
        // Disabling the channel mid-burst withdraws the grant
        if (cur_r.grantOn && !burstExt && cur_r.st != dma_xreq_pkg::ST_DONE) begin
            cur_nxt.grantOn = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cur_r <= '{st: dma_xreq_pkg::ST_IDLE, default: '0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign extGrant_n  = cur_r.grantOn ? dma_xreq_pkg::GRANT_ACTIVE
                                       : dma_xreq_pkg::GRANT_IDLE;
    assign burstActive = (cur_r.st != dma_xreq_pkg::ST_IDLE);
    assign burstChan   = cur_r.chan;
    assign readPhase   = (cur_r.st == dma_xreq_pkg::ST_READ);
    assign writePhase  = (cur_r.st == dma_xreq_pkg::ST_WRITE);
    assign burstDone   = cur_r.done;

    a_grant_in_burst : assert property (@(posedge ref_clk) disable iff (reset)
        !extGrant_n |-> burstActive)
        else $error("grant low outside a burst");

    a_grant_min_hold : assert property (@(posedge ref_clk) disable iff (reset)
        $fell(extGrant_n) && burstExt |-> !extGrant_n [*8])
        else $error("grant shorter than eight cycles");

    a_ignore_during : assert property (@(posedge ref_clk) disable iff (reset)
        burstActive && !burstDone |=> $stable(burstChan) || !burstActive)
        else $error("burst channel changed mid burst");

    a_burst_full : assert property (@(posedge ref_clk) disable iff (reset)
        $rose(burstActive) |-> readPhase [*5] ##1 writePhase [*5])
        else $error("burst not complete");

    a_grant_drop : assert property (@(posedge ref_clk) disable iff (reset)
        burstDone |-> extGrant_n && !burstActive)
        else $error("grant not released at burst end");

    a_grant_start : assert property (@(posedge ref_clk) disable iff (reset)
        $fell(extGrant_n) |-> $rose(burstActive) && request_source_select[burstChan])
        else $error("grant without external winner");

    a_demote_ext : assert property (@(posedge ref_clk) disable iff (reset)
        burstDone && cur_r.demote && extChanValid && burstActive == 1'b0
        && (chanReq & requestEnable & channel_enable_bit & ~request_source_select) != '0
        |=> burstChan != extChan)
        else $error("external request not demoted");

    a_grant_idle_hi : assert property (@(posedge ref_clk) disable iff (reset)
        !burstActive |-> extGrant_n == dma_xreq_pkg::GRANT_IDLE)
        else $error("grant not idle high");

    a_grant_with_req : assert property (@(posedge ref_clk) disable iff (reset)
        $fell(extGrant_n) |-> $past(extReq) && burstExt)
        else $error("grant without a live external request");

    a_burst_length : assert property (@(posedge ref_clk) disable iff (reset)
        $rose(burstActive) |-> ##11 burstDone)
        else $error("burst did not end after its fixed length");

    a_busy_holds : assert property (@(posedge ref_clk) disable iff (reset)
        burstActive |=> burstActive || burstDone)
        else $error("burst cut short");

    a_done_single : assert property (@(posedge ref_clk) disable iff (reset)
        burstDone |=> !burstDone)
        else $error("burst end pulse longer than one cycle");

    a_idle_serves : assert property (@(posedge ref_clk) disable iff (reset)
        !burstActive && extReq && extChanValid |=> burstActive)
        else $error("external request left unserved while idle");

    a_read_to_write : assert property (@(posedge ref_clk) disable iff (reset)
        $fell(readPhase) |-> writePhase)
        else $error("read phase not followed by write phase");

    a_grant_keep : assert property (@(posedge ref_clk) disable iff (reset)
        !extGrant_n && burstExt && (readPhase || writePhase) |=> !extGrant_n)
        else $error("grant dropped before burst end");

    a_no_grant_other : assert property (@(posedge ref_clk) disable iff (reset)
        burstActive && !burstExt |=> extGrant_n)
        else $error("grant held for a non external burst");
endmodule

// ==== design/dma_xreq_arb.sv ====
`timescale 1ns/1ps
module dma_xreq_arb #(
    parameter int unsigned NCH = dma_xreq_pkg::NUM_CH,
    parameter int unsigned CW  = dma_xreq_pkg::CH_W
) (
    input  wire logic [NCH-1:0] pending,
    input  wire logic [CW-1:0]  extChan,
    input  wire logic           extDemote,
    output logic                anyPend,
    output logic [CW-1:0]       winner
);
    // Fixed priority, lowest index highest; the external channel may be pushed last
    logic [NCH-1:0] masked;
    logic           found;
    always_comb begin
        masked = pending;
        if (extDemote && (pending & ~(NCH'(1) << extChan)) != '0) begin
            masked[extChan] = 1'b0;
        end
        found  = 1'b0;
        winner = '0;
        for (int i = 0; i < NCH; i++) begin
            if (masked[i] && !found) begin
                found  = 1'b1;
                winner = CW'(i);
            end
        end
        anyPend = found;
    end
endmodule

// ==== pkg/dma_xreq_pkg.sv ====
package dma_xreq_pkg;

    // Grant must stand at least this many system clock cycles
    localparam int unsigned GRANT_MIN_CYC  = 8;
    // Smallest burst: one read then one write
    localparam int unsigned READ_CYC       = 5;
    localparam int unsigned WRITE_CYC      = 5;
    localparam int unsigned CNT_W          = 4;
    localparam int unsigned CH_W           = 2;
    localparam int unsigned NUM_CH         = 4;
    localparam logic [0:0]  GRANT_IDLE     = 1'h1;
    localparam logic [0:0]  GRANT_ACTIVE   = 1'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11,
        ST_DONE  = 2'b10
    } burst_st_t;

endpackage

// ==== verif/test_dma_external_request_grant.sv ====
`timescale 1ns/1ps
module test_dma_external_request_grant;
    logic ref_clk = 1'b0, reset = 1'b1, start = 1'b0, extReq, extGrant_n, prevG = 1'b1;
    logic burstActive, readPhase, writePhase, burstDone;
    logic [4:0] holdCyc = 5'h0, hd;
    logic [1:0] burstChan, seq[$], ord[4];
    logic [3:0] chanReq = 4'h0, requestEnable = 4'hf, channel_enable_bit = 4'hf;
    logic [3:0] request_source_select = 4'h4, cr, rem;
    // Last hand-written burst is internal, so no demotion is carried into the random part
    logic lastExt = 1'b0;
    int err_count = 0, n_compared = 0, lowCnt = 0, rdCnt = 0, wrCnt = 0, seed = 32'h5228;
    always #50 ref_clk = ~ref_clk;
    xreq_peripheral peer (.ref_clk(ref_clk), .reset(reset), .start(start), .holdCyc(holdCyc),
        .extGrant_n(extGrant_n), .extReq(extReq));
    dma_external_request_grant dut (.ref_clk(ref_clk), .reset(reset), .extReq(extReq),
        .chanReq(chanReq), .requestEnable(requestEnable), .channel_enable_bit(channel_enable_bit),
        .request_source_select(request_source_select), .extGrant_n(extGrant_n),
        .burstActive(burstActive), .burstChan(burstChan), .readPhase(readPhase),
        .writePhase(writePhase), .burstDone(burstDone));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Fixed priority, lowest first; channel 2 is the external one and yields once after its burst
    function automatic logic [1:0] pick(input logic [3:0] m, input logic dem);
        logic [3:0] v;
        v = (dem && (m & 4'hb) != 4'h0) ? (m & 4'hb) : m;
        pick = 2'h0;
        for (int i = 3; i >= 0; i--)
            if (v[i]) pick = 2'(i);
    endfunction
    // Monitor: grant owner, grant width, burst phase lengths
    always @(posedge ref_clk) begin
        if (!reset) begin
            if (extGrant_n === 1'b0) begin
                lowCnt <= lowCnt + 1;
                check("grant owner", 1, {31'h0, burstActive & request_source_select[burstChan]
                    & requestEnable[burstChan] & channel_enable_bit[burstChan]});
            end
            if (extGrant_n === 1'b1 && prevG === 1'b0) begin
                check("grant width", 1, {31'h0, lowCnt >= dma_xreq_pkg::GRANT_MIN_CYC});
                check("grant end at done", 1, {31'h0, burstDone});
                lowCnt <= 0;
            end
            if (readPhase === 1'b1) rdCnt <= rdCnt + 1;
            if (writePhase === 1'b1) wrCnt <= wrCnt + 1;
            if (burstDone === 1'b1) begin
                check("read cycles", dma_xreq_pkg::READ_CYC, rdCnt);
                check("write cycles", dma_xreq_pkg::WRITE_CYC, wrCnt);
                rdCnt <= 0;
                wrCnt <= 0;
            end
        end
        prevG <= extGrant_n;
    end
    task automatic scen(input string nm, input logic [3:0] crq, input logic [4:0] hold,
                        input int n, input logic [1:0] f0, input logic [1:0] f1);
        int quiet;
        quiet = 0;
        seq.delete();
        holdCyc <= hold;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        chanReq <= crq;
        for (int i = 0; i < 400 && quiet < 20; i++) begin
            @(posedge ref_clk);
            if (burstDone === 1'b1) seq.push_back(burstChan);
            // Internal requesters drop their line once their burst is under way
            if (burstActive === 1'b1) chanReq[burstChan] <= 1'b0;
            quiet = (burstActive === 1'b0 && burstDone === 1'b0) ? quiet + 1 : 0;
        end
        check({nm, " burst count"}, n, seq.size());
        if (n > 0) check({nm, " first channel"}, {30'h0, f0}, {30'h0, seq[0]});
        if (n > 1) check({nm, " second channel"}, {30'h0, f1}, {30'h0, seq[1]});
        $display("test %s done", nm);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check("grant idle", 1, {31'h0, extGrant_n});
        scen("single", 4'h0, 5'h0, 1, 2'h2, 2'h0);
        scen("held", 4'h0, 5'he, 2, 2'h2, 2'h2);
        scen("higher first", 4'h1, 5'h0, 2, 2'h0, 2'h2);
        // External was served last, so the lower-ranked internal channel goes first
        scen("demote", 4'h8, 5'h0, 2, 2'h3, 2'h2);
        requestEnable <= 4'hb;
        scen("disabled", 4'h8, 5'h0, 1, 2'h3, 2'h0);
        requestEnable <= 4'hf;
        // Pending external wins first, then yields to the internal one while still held
        scen("enabled held", 4'h8, 5'he, 2, 2'h2, 2'h3);
        // Random internal mix with prompt release keeps one external burst
        for (int k = 0; k < 6; k++) begin
            cr = 4'($random(seed)) & 4'hb;
            hd = 5'($unsigned($random(seed)) % 9);
            rem = cr | 4'h4;
            for (int j = 0; j < 4; j++) begin
                if (rem != 4'h0) begin
                    ord[j] = pick(rem, lastExt);
                    rem[ord[j]] = 1'b0;
                    lastExt = (ord[j] == 2'h2);
                end
            end
            scen("random", cr, hd, $countones(cr) + 1, ord[0], ord[1]);
        end
        give_verdict;
    end
    initial begin
        #(100 * 20000);
        err_count++;
        give_verdict;
    end
endmodule

// ==== verif/xreq_peripheral.sv ====
`timescale 1ns/1ps
module xreq_peripheral (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic [4:0] holdCyc,
    input  wire logic       extGrant_n,
    output logic            extReq
);
    logic [4:0] cnt;
    logic       seen;
    // Request held until grant seen, then dropped after holdCyc cycles
    always @(posedge ref_clk) begin
        if (reset) begin
            extReq <= 1'b0;
            seen <= 1'b0;
            cnt <= 5'h0;
        end else if (start && !extReq) begin
            extReq <= 1'b1;
            seen <= 1'b0;
            cnt <= 5'h0;
        end else if (extReq && (seen || extGrant_n == 1'b0)) begin
            seen <= 1'b1;
            cnt <= cnt + 5'h1;
            if (cnt >= holdCyc) begin
                extReq <= 1'b0;
            end
        end
    end
endmodule
